// ---- jnp_pkg.sv ----
// constants for the test-port storage programming block
package jnp_pkg;
  localparam int IR_W = 4;
  localparam logic [3:0] IR_RESET_HOLD = 4'hc;
  localparam logic [3:0] IR_NVM_UNLOCK = 4'h4;
  localparam logic [3:0] IR_NVM_COMMAND = 4'h5;
  localparam logic [3:0] IR_PAGE_FILL = 4'h6;
  localparam logic [3:0] IR_PAGE_DUMP = 4'h7;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam int DR_W = 16;
  localparam int CMD_W = 15;
  localparam logic [15:0] UNLOCK_KEY = 16'ha370;
  localparam logic [6:0] CMD_ADDR_HI = 7'h07;
  localparam logic [6:0] CMD_ADDR_LO = 7'h03;
  localparam int PC_W = 16;
  localparam int FILL_MIN_TCK = 11;
  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h3, TAP_CAP_DR = 4'h2,
    TAP_SH_DR = 4'h6, TAP_EX1_DR = 4'h7, TAP_PA_DR = 4'h5, TAP_EX2_DR = 4'h4,
    TAP_UPD_DR = 4'hc, TAP_SEL_IR = 4'hd, TAP_CAP_IR = 4'hf, TAP_SH_IR = 4'he,
    TAP_EX1_IR = 4'ha, TAP_PA_IR = 4'hb, TAP_EX2_IR = 4'h9, TAP_UPD_IR = 4'h8
  } jnp_tap_t;
endpackage

// ---- jnp_sync.sv ----
// two-flop synchroniser for one pin
`timescale 1ns/1ns
module jnp_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_d,
  output logic o_q
);
  logic meta_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= 1'b0;
      o_q <= 1'b0;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end
endmodule // jnp_sync

// ---- jnp_top.sv ----
// test-port programming front end for on-chip non-volatile storage
`timescale 1ns/1ns
module jnp_top (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_TCK,
  input wire logic I_TMS,
  input wire logic I_TDI,
  input wire logic [14:0] I_CMD_RDATA,
  input wire logic [7:0] I_FL_RDATA,
  output logic O_TDO,
  output logic O_RESET_HOLD,
  output logic O_PROG_MODE,
  output logic O_CMD_VALID,
  output logic [14:0] O_CMD_DATA,
  output logic O_PB_WE,
  output logic O_WR_HI,
  output logic [7:0] O_PB_DATA,
  output logic [15:0] O_PC,
  output logic O_RD_HI
);
  logic tck_s, tms_s, tdi_s, tck_d_q;
  logic tck_rise, tck_fall;
  jnp_pkg::jnp_tap_t tap_q;
  logic [3:0] ir_q, ir_sh_q;
  logic [15:0] dr_q;
  logic first_q;
  logic cap_dr, upd_dr, upd_ir, sh_dr;
  logic unlock_ok;

  jnp_sync u_sync_tck (.i_clk(I_CLK), .i_rst(I_RST), .i_d(I_TCK), .o_q(tck_s));
  jnp_sync u_sync_tms (.i_clk(I_CLK), .i_rst(I_RST), .i_d(I_TMS), .o_q(tms_s));
  jnp_sync u_sync_tdi (.i_clk(I_CLK), .i_rst(I_RST), .i_d(I_TDI), .o_q(tdi_s));

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      tck_d_q <= 1'b0;
    end else begin
      tck_d_q <= tck_s;
    end
  end
  assign tck_rise = tck_s & ~tck_d_q;
  assign tck_fall = ~tck_s & tck_d_q;
  assign cap_dr = tck_rise && (tap_q == jnp_pkg::TAP_CAP_DR);
  assign sh_dr = tck_rise && (tap_q == jnp_pkg::TAP_SH_DR);
  assign upd_dr = tck_rise && (tap_q == jnp_pkg::TAP_UPD_DR);
  assign upd_ir = tck_rise && (tap_q == jnp_pkg::TAP_UPD_IR);
  assign unlock_ok = O_RESET_HOLD && (dr_q == jnp_pkg::UNLOCK_KEY);

  // tap state walk on each sampled rising test-clock edge
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      tap_q <= jnp_pkg::TAP_RESET;
    end else if (tck_rise) begin
      unique case (tap_q)
        jnp_pkg::TAP_RESET: tap_q <= tms_s ? jnp_pkg::TAP_RESET : jnp_pkg::TAP_IDLE;
        jnp_pkg::TAP_IDLE: tap_q <= tms_s ? jnp_pkg::TAP_SEL_DR : jnp_pkg::TAP_IDLE;
        jnp_pkg::TAP_SEL_DR: tap_q <= tms_s ? jnp_pkg::TAP_SEL_IR : jnp_pkg::TAP_CAP_DR;
        jnp_pkg::TAP_CAP_DR: tap_q <= tms_s ? jnp_pkg::TAP_EX1_DR : jnp_pkg::TAP_SH_DR;
        jnp_pkg::TAP_SH_DR: tap_q <= tms_s ? jnp_pkg::TAP_EX1_DR : jnp_pkg::TAP_SH_DR;
        jnp_pkg::TAP_EX1_DR: tap_q <= tms_s ? jnp_pkg::TAP_UPD_DR : jnp_pkg::TAP_PA_DR;
        jnp_pkg::TAP_PA_DR: tap_q <= tms_s ? jnp_pkg::TAP_EX2_DR : jnp_pkg::TAP_PA_DR;
        jnp_pkg::TAP_EX2_DR: tap_q <= tms_s ? jnp_pkg::TAP_UPD_DR : jnp_pkg::TAP_SH_DR;
        jnp_pkg::TAP_UPD_DR: tap_q <= tms_s ? jnp_pkg::TAP_SEL_DR : jnp_pkg::TAP_IDLE;
        jnp_pkg::TAP_SEL_IR: tap_q <= tms_s ? jnp_pkg::TAP_RESET : jnp_pkg::TAP_CAP_IR;
        jnp_pkg::TAP_CAP_IR: tap_q <= tms_s ? jnp_pkg::TAP_EX1_IR : jnp_pkg::TAP_SH_IR;
        jnp_pkg::TAP_SH_IR: tap_q <= tms_s ? jnp_pkg::TAP_EX1_IR : jnp_pkg::TAP_SH_IR;
        jnp_pkg::TAP_EX1_IR: tap_q <= tms_s ? jnp_pkg::TAP_UPD_IR : jnp_pkg::TAP_PA_IR;
        jnp_pkg::TAP_PA_IR: tap_q <= tms_s ? jnp_pkg::TAP_EX2_IR : jnp_pkg::TAP_PA_IR;
        jnp_pkg::TAP_EX2_IR: tap_q <= tms_s ? jnp_pkg::TAP_UPD_IR : jnp_pkg::TAP_SH_IR;
        jnp_pkg::TAP_UPD_IR: tap_q <= tms_s ? jnp_pkg::TAP_SEL_DR : jnp_pkg::TAP_IDLE;
      endcase
    end
  end

  // instruction register; test-logic reset falls back to bypass
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      ir_sh_q <= 4'h0;
      ir_q <= jnp_pkg::IR_BYPASS;
    end else if (tck_rise) begin
      if (tap_q == jnp_pkg::TAP_RESET) begin
        ir_q <= jnp_pkg::IR_BYPASS;
      end else if (tap_q == jnp_pkg::TAP_CAP_IR) begin
        ir_sh_q <= jnp_pkg::IR_CAPTURE;
      end else if (tap_q == jnp_pkg::TAP_SH_IR) begin
        ir_sh_q <= {tdi_s, ir_sh_q[3:1]};
      end else if (tap_q == jnp_pkg::TAP_UPD_IR) begin
        ir_q <= ir_sh_q;
      end
    end
  end

  // shared data shift register; length follows the instruction
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      dr_q <= 16'h0000;
    end else if (cap_dr) begin
      unique case (ir_q)
        jnp_pkg::IR_NVM_COMMAND: dr_q <= {1'b0, I_CMD_RDATA};
        jnp_pkg::IR_PAGE_DUMP: dr_q <= {8'h00, I_FL_RDATA};
        default: dr_q <= 16'h0000;
      endcase
    end else if (sh_dr) begin
      unique case (ir_q)
        jnp_pkg::IR_NVM_UNLOCK: dr_q <= {tdi_s, dr_q[15:1]};
        jnp_pkg::IR_NVM_COMMAND: dr_q <= {1'b0, tdi_s, dr_q[14:1]};
        jnp_pkg::IR_PAGE_FILL, jnp_pkg::IR_PAGE_DUMP: dr_q <= {8'h00, tdi_s, dr_q[7:1]};
        default: dr_q <= {15'h0000, tdi_s};
      endcase
    end
  end

  // test data out changes on the falling edge so the far end samples it stable
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_TDO <= 1'b0;
    end else if (tck_fall) begin
      if (tap_q == jnp_pkg::TAP_SH_IR) begin
        O_TDO <= ir_sh_q[0];
      end else if (tap_q == jnp_pkg::TAP_SH_DR) begin
        O_TDO <= dr_q[0];
      end
    end
  end

  // reset hold and unlock state
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_RESET_HOLD <= 1'b0;
      O_PROG_MODE <= 1'b0;
    end else if (upd_dr) begin
      if (ir_q == jnp_pkg::IR_RESET_HOLD) begin
        O_RESET_HOLD <= dr_q[0];
        if (!dr_q[0]) begin
          O_PROG_MODE <= 1'b0;
        end
      end else if (ir_q == jnp_pkg::IR_NVM_UNLOCK) begin
        O_PROG_MODE <= unlock_ok;
      end
    end
  end

  // commands go to the store only once unlocked; fuse and lock data bits
  // pass unaltered, so a zero reaches the store as program
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_CMD_VALID <= 1'b0;
      O_CMD_DATA <= 15'h0000;
    end else begin
      O_CMD_VALID <= upd_dr && (ir_q == jnp_pkg::IR_NVM_COMMAND) && O_PROG_MODE;
      if (upd_dr && (ir_q == jnp_pkg::IR_NVM_COMMAND) && O_PROG_MODE) begin
        O_CMD_DATA <= dr_q[14:0];
      end
    end
  end

  // page buffer access is flash only; eeprom never sees these strobes
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_PC <= 16'h0000;
      O_RD_HI <= 1'b0;
      first_q <= 1'b0;
      O_PB_WE <= 1'b0;
      O_WR_HI <= 1'b0;
      O_PB_DATA <= 8'h00;
    end else begin
      O_PB_WE <= 1'b0;
      if (upd_ir) begin
        O_RD_HI <= 1'b0;
        first_q <= 1'b1;
      end else if (upd_dr && O_PROG_MODE && (ir_q == jnp_pkg::IR_NVM_COMMAND)) begin
        if (dr_q[14:8] == jnp_pkg::CMD_ADDR_HI) begin
          O_PC[15:8] <= dr_q[7:0];
        end else if (dr_q[14:8] == jnp_pkg::CMD_ADDR_LO) begin
          O_PC[7:0] <= dr_q[7:0];
        end
      end else if (upd_dr && O_PROG_MODE && (ir_q == jnp_pkg::IR_PAGE_FILL)) begin
        // pre-increment before each low byte except the first, so the last
        // byte of a page never moves the counter into the next page
        if (!O_RD_HI && !first_q) begin
          O_PC <= O_PC + 16'h0001;
        end
        O_PB_WE <= 1'b1;
        O_WR_HI <= O_RD_HI;
        O_PB_DATA <= dr_q[7:0];
        O_RD_HI <= ~O_RD_HI;
        first_q <= 1'b0;
      end else if (cap_dr && O_PROG_MODE && (ir_q == jnp_pkg::IR_PAGE_DUMP)) begin
        if (O_RD_HI) begin
          O_PC <= O_PC + 16'h0001;
        end
        O_RD_HI <= ~O_RD_HI;
      end
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  key_unlock_a: assert property (upd_dr && ir_q == jnp_pkg::IR_NVM_UNLOCK
    && unlock_ok |=> O_PROG_MODE) else $error("correct key did not unlock");
  bad_key_a: assert property (upd_dr && ir_q == jnp_pkg::IR_NVM_UNLOCK
    && !unlock_ok |=> !O_PROG_MODE) else $error("wrong key left block unlocked");
  cmd_gate_a: assert property (O_CMD_VALID |-> $past(O_PROG_MODE))
    else $error("command passed while locked");
  fill_write_a: assert property (upd_dr && ir_q == jnp_pkg::IR_PAGE_FILL
    && O_PROG_MODE |=> O_PB_WE && O_PB_DATA == $past(dr_q[7:0]))
    else $error("page fill byte not written");
  fill_alt_a: assert property (O_PB_WE |-> O_WR_HI == !O_RD_HI ##1 !O_PB_WE)
    else $error("page fill byte order broken");
  fill_entry_a: assert property (upd_ir |=> !O_RD_HI && first_q)
    else $error("fill did not restart at low byte");
  dump_cap_a: assert property (cap_dr && ir_q == jnp_pkg::IR_PAGE_DUMP
    |=> dr_q[7:0] == $past(I_FL_RDATA)) else $error("dump byte not captured");
  dump_inc_a: assert property (cap_dr && ir_q == jnp_pkg::IR_PAGE_DUMP && O_PROG_MODE
    && O_RD_HI |=> O_PC == $past(O_PC) + 16'h0001) else $error("dump counter stuck");
  fill_preinc_a: assert property (upd_dr && ir_q == jnp_pkg::IR_PAGE_FILL
    && O_PROG_MODE && !O_RD_HI && !first_q |=> O_PC == $past(O_PC) + 16'h0001)
    else $error("fill counter not pre-incremented");

  unlock_c: cover property (!O_PROG_MODE ##1 O_PROG_MODE);
  fill_word_c: cover property (O_PB_WE && O_WR_HI);
  dump_word_c: cover property (cap_dr && ir_q == jnp_pkg::IR_PAGE_DUMP && O_RD_HI);
  cmd_c: cover property (O_CMD_VALID);
endmodule // jnp_top

// ---- jnp_prog_model.sv ----
// behavioural test-port programmer that drives instruction and data scans
`timescale 1ns/1ns
module jnp_prog_model (
  input wire logic i_clk,
  input wire logic i_tdo,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi
);
  // the test clock stands low between frames
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end

  // one test clock of 800 ns; tdo is taken just before the rise
  task automatic pulse(input logic m, input logic d, output logic q);
    o_tms <= m;
    o_tdi <= d;
    repeat (4) @(posedge i_clk);
    q = i_tdo;
    o_tck <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_tck <= 1'b0;
  endtask

  // data line is not shifted here, so it toggles instead of holding
  task automatic idle(input int n);
    logic q;
    repeat (n) pulse(1'b0, ~o_tdi, q);
  endtask

  // from run-test/idle through capture, shift (lsb first), update, back to idle
  task automatic scan(input logic ir, input int n, input logic [15:0] din,
                      output logic [15:0] dout);
    logic q;
    dout = '0;
    pulse(1'b1, ~o_tdi, q);
    if (ir) pulse(1'b1, ~o_tdi, q);
    pulse(1'b0, ~o_tdi, q);
    pulse(1'b0, ~o_tdi, q);
    for (int i = 0; i < n; i++) begin
      pulse(i == n - 1, din[i], q);
      dout[i] = q;
    end
    pulse(1'b1, ~o_tdi, q);
    pulse(1'b0, ~o_tdi, q);
    // the update strobes last one cycle; let them reach the bench's monitors first
    repeat (2) @(posedge i_clk);
  endtask
endmodule // jnp_prog_model

// ---- jtag_nvm_programming_tb.sv ----
// self-checking bench for the test-port storage programming block
`timescale 1ns/1ns
module jtag_nvm_programming_tb;
  logic I_CLK, I_RST, tck, tms, tdi, tdo, reset_hold, prog_mode, cmd_valid, pb_we, wr_hi, rd_hi;
  logic [14:0] cmd_rdata, cmd_data;
  logic [7:0] fl_rdata, pb_data;
  logic [15:0] pc, d;
  logic [24:0] pb_log [$];
  int miscompares, check_count, cmd_seen;
  // stand-in command words; the block passes them through untouched, values arbitrary
  localparam logic [14:0] CMD_ERASE = 15'h2380;
  localparam logic [14:0] CMD_FLASH_WR = 15'h2310;
  localparam logic [14:0] CMD_FLASH_RD = 15'h2302;
  localparam logic [14:0] CMD_PAGE_WR = 15'h3500;
  localparam logic [14:0] CMD_EE_WR = 15'h2311;
  localparam logic [14:0] CMD_EE_RD = 15'h2303;
  localparam logic [14:0] CMD_FUSE_WR = 15'h2340;

  jnp_top DUT (.I_CLK(I_CLK), .I_RST(I_RST), .I_TCK(tck), .I_TMS(tms), .I_TDI(tdi),
    .I_CMD_RDATA(cmd_rdata), .I_FL_RDATA(fl_rdata), .O_TDO(tdo), .O_RESET_HOLD(reset_hold),
    .O_PROG_MODE(prog_mode), .O_CMD_VALID(cmd_valid), .O_CMD_DATA(cmd_data), .O_PB_WE(pb_we),
    .O_WR_HI(wr_hi), .O_PB_DATA(pb_data), .O_PC(pc), .O_RD_HI(rd_hi));
  jnp_prog_model p (.i_clk(I_CLK), .i_tdo(tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));

  always #50 I_CLK = ~I_CLK;
  // flash model: byte depends on word address and byte half
  always @(posedge I_CLK) begin
    fl_rdata <= pc[7:0] ^ {7'h00, rd_hi} ^ 8'ha5;
    if (cmd_valid === 1'b1) cmd_seen++;
    if (pb_we === 1'b1) pb_log.push_back({wr_hi, pb_data, pc});
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic ir(input logic [3:0] code);
    p.scan(1'b1, 4, {12'h000, code}, d);
  endtask
  task automatic cmd(input logic [14:0] c);
    p.scan(1'b0, 15, {1'b0, c}, d);
  endtask
  task automatic cmd_ignored();
    int n;
    n = cmd_seen;
    ir(jnp_pkg::IR_NVM_COMMAND);
    cmd(15'h2308);
    check(16'(cmd_seen - n), 16'h0000);
  endtask
  task automatic cmd_pass(input logic [14:0] c);
    int n;
    n = cmd_seen;
    cmd(c);
    check(16'(cmd_seen - n), 16'h0001);
    check({1'b0, cmd_data}, {1'b0, c});
  endtask

  task automatic test_entry();
    cmd_ignored();
    ir(jnp_pkg::IR_RESET_HOLD);
    p.scan(1'b0, 1, 16'h0001, d);
    check({15'h0, reset_hold}, 16'h0001);
    ir(jnp_pkg::IR_NVM_UNLOCK);
    p.scan(1'b0, 16, 16'ha371, d);
    check({15'h0, prog_mode}, 16'h0000);
    p.scan(1'b0, 16, 16'ha370, d);
    check({15'h0, prog_mode}, 16'h0001);
    $display("entry test done");
  endtask

  task automatic test_commands();
    logic [14:0] tbl [5] = '{15'h2304, 15'h2308, 15'h2320, 15'h13ea, 15'h2300};
    int n;
    ir(jnp_pkg::IR_NVM_COMMAND);
    foreach (tbl[k]) begin
      n = cmd_seen;
      cmd(tbl[k]);
      check(16'(cmd_seen - n), 16'h0001);
      check({1'b0, cmd_data}, {1'b0, tbl[k]});
      check(d, {1'b0, cmd_rdata});
    end
    for (int a = 0; a < 3; a++) begin
      cmd(15'h0300 | 15'(a));
      check({8'h00, pc[7:0]}, 16'(a));
    end
    $display("command test done");
  endtask

  task automatic test_sequences();
    ir(jnp_pkg::IR_NVM_COMMAND);
    cmd_pass(CMD_ERASE);
    cmd_pass(CMD_FLASH_WR);
    cmd_pass(CMD_FLASH_RD);
    cmd_pass(CMD_EE_WR);
    cmd_pass(CMD_EE_RD);
    cmd_pass(CMD_FUSE_WR);
    // mixed zeros and ones must reach the store with their polarity kept
    cmd_pass(15'h13a6);
    cmd_pass(15'h2308);
    cmd_pass(15'h0300);
    check({8'h00, pc[7:0]}, 16'h0000);
    cmd_pass(15'h3600);
    $display("sequence test done");
  endtask

  task automatic test_fill();
    ir(jnp_pkg::IR_NVM_COMMAND);
    cmd(15'h0712);
    cmd(15'h0330);
    check(pc, 16'h1230);
    ir(jnp_pkg::IR_PAGE_FILL);
    pb_log.delete();
    // each 8-bit scan takes 13 test clocks, above the 11 needed between updates
    for (int k = 0; k < 4; k++) p.scan(1'b0, 8, 16'(8'h11 * (k + 1)), d);
    check(16'(pb_log.size()), 16'h0004);
    foreach (pb_log[k]) begin
      check({15'h0, pb_log[k][24]}, 16'(k % 2));
      check({8'h00, pb_log[k][23:16]}, 16'(8'h11 * (k + 1)));
      check(pb_log[k][15:0], 16'h1230 + 16'(k / 2));
    end
    ir(jnp_pkg::IR_NVM_COMMAND);
    cmd_pass(CMD_PAGE_WR);
    $display("fill test done");
  endtask

  task automatic test_dump();
    ir(jnp_pkg::IR_NVM_COMMAND);
    cmd(15'h0712);
    cmd(15'h0330);
    ir(jnp_pkg::IR_PAGE_DUMP);
    for (int k = 0; k < 4; k++) begin
      p.scan(1'b0, 8, 16'h0000, d);
      check({8'h00, d[7:0]}, {8'h00, (8'h30 + 8'(k / 2)) ^ 8'(k % 2) ^ 8'ha5});
      check({15'h0, rd_hi}, 16'((k + 1) % 2));
    end
    check(pc, 16'h1232);
    $display("dump test done");
  endtask

  task automatic test_exit();
    ir(jnp_pkg::IR_NVM_COMMAND);
    cmd(15'h2300);
    ir(jnp_pkg::IR_NVM_UNLOCK);
    p.scan(1'b0, 16, 16'h0000, d);
    check({15'h0, prog_mode}, 16'h0000);
    ir(jnp_pkg::IR_RESET_HOLD);
    p.scan(1'b0, 1, 16'h0000, d);
    check({15'h0, reset_hold}, 16'h0000);
    cmd_ignored();
    $display("exit test done");
  endtask

  initial begin
    I_CLK = 1'b0;
    I_RST = 1'b1;
    cmd_rdata = 15'h5a3c;
    repeat (6) @(posedge I_CLK);
    I_RST <= 1'b0;
    repeat (3) @(posedge I_CLK);
    check({14'h0, prog_mode, reset_hold}, 16'h0000);
    p.idle(1);
    test_entry();
    test_commands();
    test_sequences();
    test_fill();
    test_dump();
    test_exit();
    tally_and_finish();
  end

  // the full sequence needs about 6,800 system clocks; the limit leaves ample slack
  initial begin
    repeat (60000) @(posedge I_CLK);
    miscompares++;
    tally_and_finish();
  end
endmodule // jtag_nvm_programming_tb
